// ==== odrs_core.v ====
// out-of-order issue and in-order retirement for two threads
// assumes front end, thread control and irq inputs share ref_clk
`timescale 1ns/1ns
`include "odrs_defs.vh"

// Behaviour
// - up to six micro-operations issue per clock cycle
// - most pipes take a new micro-operation every cycle
// - two simple integer operations start per cycle
// - floating-point operations start at most once per two cycles
// - an operation issues once its sources and a pipe are ready
// - younger independent operations pass a stalled older one
// - retirement updates state strictly in program order
// - stores commit in order at retirement, total store order
// - faults are raised only at retirement, never speculatively
// - after a fault committed state is precise at that op
// - an operation retires once complete with result written
// - at most three operations commit per cycle
// - a reorder queue holds, commits and orders faults
// - retired branches update the branch target store
// - two logical processors with private architectural state
// - per-thread copies of data and system registers
// - each logical processor has its own interrupt controller
// - threads share one execution engine, interleaved
// - each thread starts, is interrupted and halts independently
// - a lone active thread may use all shared resources
module odrs_core #(
   parameter DEPTH = 8,
   parameter AW = 3,
   parameter RW = 3,
   parameter DW = 16
) (
   input wire ref_clk,
   input wire reset_n,
   input wire fe_valid,
   input wire fe_thread,
   input wire [2:0] fe_class,
   input wire [RW-1:0] fe_src1,
   input wire [RW-1:0] fe_src2,
   input wire [RW-1:0] fe_dst,
   input wire [DW-1:0] fe_val,
   input wire fe_fault,
   input wire fe_mispred,
   output reg [1:0] fe_ready_reg,
   input wire [1:0] thr_start,
   input wire [1:0] thr_halt,
   input wire [1:0] irq_req,
   output wire [1:0] thr_running,
   output reg [1:0] irq_ack_reg,
   output reg [1:0] flush_reg,
   output reg [1:0] exc_reg,
   output reg [2:0] issue_cnt_reg,
   output reg [1:0] ret_cnt_reg,
   output reg st_v_reg,
   output reg st_thr_reg,
   output reg [RW-1:0] st_addr_reg,
   output reg [DW-1:0] st_data_reg,
   output reg bts_v_reg,
   output reg bts_thr_reg,
   output reg [DW-1:0] bts_target_reg,
   output reg bts_mis_reg,
   input wire [RW-1:0] dbg_reg,
   output wire [DW-1:0] dbg_data_t0,
   output wire [DW-1:0] dbg_data_t1
);

   localparam NP = `ODRS_NPIPE;
   localparam RN = `ODRS_RET_W;
   localparam NT = `ODRS_NTHR;

   function integer lat_of;
      input integer p;
      begin
         case (p)
            `ODRS_P_FP: lat_of = `ODRS_LAT_FP;
            `ODRS_P_LD: lat_of = `ODRS_LAT_LD;
            `ODRS_P_ST: lat_of = `ODRS_LAT_ST;
            `ODRS_P_BR: lat_of = `ODRS_LAT_BR;
            default: lat_of = `ODRS_LAT_ALU;
         endcase
      end
   endfunction

   // ==========================================================
   // reorder completion queue
   reg [AW-1:0] head_reg;
   reg [AW-1:0] tail_reg;
   reg [AW:0] cnt_reg;
   reg fp_gap_reg;
   reg e_v [0:DEPTH-1];
   reg e_done [0:DEPTH-1];
   reg e_iss [0:DEPTH-1];
   reg e_kill [0:DEPTH-1];
   reg e_thr [0:DEPTH-1];
   reg e_wr [0:DEPTH-1];
   reg e_flt [0:DEPTH-1];
   reg e_mis [0:DEPTH-1];
   reg [2:0] e_cls [0:DEPTH-1];
   reg [RW-1:0] e_s1 [0:DEPTH-1];
   reg [RW-1:0] e_s2 [0:DEPTH-1];
   reg [RW-1:0] e_dst [0:DEPTH-1];
   reg [DW-1:0] e_val [0:DEPTH-1];

   reg [NP-1:0] pick_v;
   reg [AW-1:0] pick_idx [0:NP-1];
   reg [DEPTH-1:0] iss_mask;
   reg [DEPTH-1:0] cmp_mask;
   reg [DEPTH-1:0] kmask;
   reg [RN-1:0] ret_w;
   reg [2:0] npop;
   reg [2:0] nis;
   reg [1:0] ncom;
   reg [1:0] fl_now;
   reg [1:0] exc_now;
   reg [1:0] int_take;
   reg [1:0] kill_now;
   reg acc;
   reg [AW:0] cnt_next;
   reg st_hit;
   reg br_hit;
   reg ev_v;
   reg ev_thr;
   reg [AW-1:0] ev_age;
   reg stop;
   reg rdy;
   reg [AW-1:0] ik;
   reg [AW-1:0] ij;
   reg [AW-1:0] ci;
   reg [AW-1:0] st_idx;
   reg [AW-1:0] br_idx;
   reg [1:0] run_next;
   reg [AW-1:0] am;
   reg [2:0] pp;
   reg [RN*RW-1:0] wr_dst;
   reg [RN*DW-1:0] wr_val;
   reg [NT*RN-1:0] wr_v;
   integer k;
   integer j;
   integer p;
   integer ck;
   integer cj;
   integer m;

   wire [NP-1:0] out_v;
   wire [NP*AW-1:0] out_idx;
   wire [NT-1:0] irq_pend;
   wire [DW-1:0] dbg_data [0:NT-1];

   // ==========================================================
   // issue selection, oldest ready first per pipe
   always @* begin
      pick_v = {NP{1'b0}};
      iss_mask = {DEPTH{1'b0}};
      for (p = 0; p < NP; p = p + 1) begin
         pick_idx[p] = {AW{1'b0}};
      end
      pp = 3'h0;
      for (ck = 0; ck < DEPTH; ck = ck + 1) begin
         ci = head_reg + ck[AW-1:0];
         rdy = e_v[ci] & ~e_iss[ci] & ~e_kill[ci];
         for (cj = 0; cj < DEPTH; cj = cj + 1) begin
            ij = head_reg + cj[AW-1:0];
            if (cj < ck && e_v[ij] && e_thr[ij] == e_thr[ci]) begin
               // producer still outstanding
               if (!e_done[ij] && e_wr[ij] && (e_dst[ij] == e_s1[ci] ||
                   e_dst[ij] == e_s2[ci])) begin
                  rdy = 1'b0;
               end
               // loads wait behind older stores of the thread
               if (e_cls[ci] == `ODRS_CL_LD && e_cls[ij] == `ODRS_CL_ST) begin
                  rdy = 1'b0;
               end
            end
         end
         case (e_cls[ci])
            `ODRS_CL_FP: pp = `ODRS_P_FP;
            `ODRS_CL_LD: pp = `ODRS_P_LD;
            `ODRS_CL_ST: pp = `ODRS_P_ST;
            `ODRS_CL_BR: pp = `ODRS_P_BR;
            default: pp = pick_v[`ODRS_P_ALU0] ? `ODRS_P_ALU1 :
                          `ODRS_P_ALU0;
         endcase
         if (pp == `ODRS_P_FP && fp_gap_reg) begin
            rdy = 1'b0;
         end
         // stalled older entries do not block this one
         if (rdy && !pick_v[pp]) begin
            pick_v[pp] = 1'b1;
            pick_idx[pp] = ci;
            iss_mask[ci] = 1'b1;
         end
      end
      nis = 3'h0;
      cmp_mask = {DEPTH{1'b0}};
      for (p = 0; p < NP; p = p + 1) begin
         nis = nis + {2'h0, pick_v[p]};
         if (out_v[p]) begin
            cmp_mask[out_idx[p*AW +: AW]] = 1'b1;
         end
      end
   end

   // ==========================================================
   // in-order retirement, up to RN per cycle
   always @* begin
      stop = 1'b0;
      npop = 3'h0;
      ncom = 2'h0;
      ret_w = {RN{1'b0}};
      st_hit = 1'b0;
      br_hit = 1'b0;
      ev_v = 1'b0;
      ev_thr = 1'b0;
      ev_age = {AW{1'b0}};
      exc_now = 2'h0;
      fl_now = 2'h0;
      wr_v = {(NT*RN){1'b0}};
      wr_dst = {(RN*RW){1'b0}};
      wr_val = {(RN*DW){1'b0}};
      st_idx = {AW{1'b0}};
      br_idx = {AW{1'b0}};
      for (j = 0; j < NT; j = j + 1) begin
         int_take[j] = irq_pend[j] & thr_running[j];
         // mirrors the context run state for the same edge
         run_next[j] = thr_running[j] ? ~thr_halt[j] : thr_start[j];
      end
      for (k = 0; k < RN; k = k + 1) begin
         ik = head_reg + k[AW-1:0];
         wr_dst[k*RW +: RW] = e_dst[ik];
         wr_val[k*DW +: DW] = e_val[ik];
         if (stop) begin
            stop = 1'b1;
         end else if (!e_v[ik] || !e_done[ik] || int_take[e_thr[ik]]) begin
            stop = 1'b1;
         end else if (e_kill[ik]) begin
            npop = npop + 3'h1;
         end else if (e_flt[ik]) begin
            // faulting op is dropped, nothing younger of its thread survives
            npop = npop + 3'h1;
            exc_now[e_thr[ik]] = 1'b1;
            fl_now[e_thr[ik]] = 1'b1;
            ev_v = 1'b1;
            ev_thr = e_thr[ik];
            ev_age = k[AW-1:0];
            stop = 1'b1;
         end else if ((e_cls[ik] == `ODRS_CL_ST && st_hit) ||
                      (e_cls[ik] == `ODRS_CL_BR && br_hit)) begin
            stop = 1'b1;
         end else begin
            npop = npop + 3'h1;
            ncom = ncom + 2'h1;
            ret_w[k] = 1'b1;
            wr_v[e_thr[ik]*RN + k] = e_wr[ik];
            if (e_cls[ik] == `ODRS_CL_ST) begin
               st_hit = 1'b1;
               st_idx = ik;
            end
            if (e_cls[ik] == `ODRS_CL_BR) begin
               br_hit = 1'b1;
               br_idx = ik;
               if (e_mis[ik]) begin
                  fl_now[e_thr[ik]] = 1'b1;
                  ev_v = 1'b1;
                  ev_thr = e_thr[ik];
                  ev_age = k[AW-1:0];
                  stop = 1'b1;
               end
            end
         end
      end
      kill_now = fl_now | int_take;
      for (k = 0; k < DEPTH; k = k + 1) begin
         am = k[AW-1:0] - head_reg;
         kmask[k] = e_v[k] & ((ev_v & e_thr[k] == ev_thr & am > ev_age) |
                    int_take[e_thr[k]]);
      end
      // a thread being flushed drops what it offers now
      acc = fe_valid & fe_ready_reg[fe_thread] & ~kill_now[fe_thread] &
            ~flush_reg[fe_thread];
      cnt_next = cnt_reg - {{(AW-2){1'b0}}, npop} + {{AW{1'b0}}, acc};
   end

   // ==========================================================
   // queue state, shared by both threads with no partition
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         head_reg <= {AW{1'b0}};
         tail_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
         fp_gap_reg <= 1'b0;
         fe_ready_reg <= 2'h0;
         for (m = 0; m < DEPTH; m = m + 1) begin
            e_v[m] <= 1'b0;
            e_done[m] <= 1'b0;
            e_iss[m] <= 1'b0;
            e_kill[m] <= 1'b0;
         end
      end else begin
         for (m = 0; m < DEPTH; m = m + 1) begin
            if (iss_mask[m]) begin
               e_iss[m] <= 1'b1;
            end
            if (cmp_mask[m]) begin
               e_done[m] <= 1'b1;
            end
            if (kmask[m]) begin
               e_kill[m] <= 1'b1;
               if (!e_iss[m] && !iss_mask[m]) begin
                  e_done[m] <= 1'b1;
               end
            end
         end
         for (m = 0; m < RN; m = m + 1) begin
            if (m < npop) begin
               e_v[head_reg + m[AW-1:0]] <= 1'b0;
            end
         end
         if (acc) begin
            e_v[tail_reg] <= 1'b1;
            e_done[tail_reg] <= 1'b0;
            e_iss[tail_reg] <= 1'b0;
            e_kill[tail_reg] <= 1'b0;
            e_thr[tail_reg] <= fe_thread;
            e_cls[tail_reg] <= fe_class;
            e_wr[tail_reg] <= (fe_class == `ODRS_CL_ALU) ||
               (fe_class == `ODRS_CL_FP) || (fe_class == `ODRS_CL_LD);
            e_s1[tail_reg] <= fe_src1;
            e_s2[tail_reg] <= fe_src2;
            e_dst[tail_reg] <= fe_dst;
            e_val[tail_reg] <= fe_val;
            e_flt[tail_reg] <= fe_fault;
            e_mis[tail_reg] <= fe_mispred;
         end
         head_reg <= head_reg + npop[AW-1:0];
         tail_reg <= tail_reg + {{(AW-1){1'b0}}, acc};
         cnt_reg <= cnt_next;
         fp_gap_reg <= pick_v[`ODRS_P_FP];
         for (m = 0; m < NT; m = m + 1) begin
            // whole queue open to either thread
            fe_ready_reg[m] <= run_next[m] & (cnt_next < DEPTH) &
                               ~kill_now[m];
         end
      end
   end

   // ==========================================================
   // registered event outputs
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         irq_ack_reg <= 2'h0;
         flush_reg <= 2'h0;
         exc_reg <= 2'h0;
         issue_cnt_reg <= 3'h0;
         ret_cnt_reg <= 2'h0;
         st_v_reg <= 1'b0;
         st_thr_reg <= 1'b0;
         st_addr_reg <= {RW{1'b0}};
         st_data_reg <= {DW{1'b0}};
         bts_v_reg <= 1'b0;
         bts_thr_reg <= 1'b0;
         bts_target_reg <= {DW{1'b0}};
         bts_mis_reg <= 1'b0;
      end else begin
         irq_ack_reg <= int_take;
         flush_reg <= kill_now;
         exc_reg <= exc_now;
         issue_cnt_reg <= nis;
         ret_cnt_reg <= ncom;
         st_v_reg <= st_hit;
         bts_v_reg <= br_hit;
         if (st_hit) begin
            st_thr_reg <= e_thr[st_idx];
            st_addr_reg <= e_dst[st_idx];
            st_data_reg <= e_val[st_idx];
         end
         if (br_hit) begin
            bts_thr_reg <= e_thr[br_idx];
            bts_target_reg <= e_val[br_idx];
            bts_mis_reg <= e_mis[br_idx];
         end
      end
   end

   // ==========================================================
   // execution pipes and per-thread contexts
   genvar g;
   generate
      for (g = 0; g < NP; g = g + 1) begin : pipe
         odrs_pipe #(
            .LAT(lat_of(g)),
            .IW(AW)
         ) u_pipe (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .in_v(pick_v[g]),
            .in_idx(pick_idx[g]),
            .out_v(out_v[g]),
            .out_idx(out_idx[g*AW +: AW])
         );
      end
      for (g = 0; g < NT; g = g + 1) begin : thr
         odrs_thread_ctx #(
            .RW(RW),
            .DW(DW),
            .NW(RN)
         ) u_ctx (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .start(thr_start[g]),
            .halt(thr_halt[g]),
            .irq(irq_req[g]),
            .irq_take(int_take[g]),
            .wr_v(wr_v[g*RN +: RN]),
            .wr_dst(wr_dst),
            .wr_val(wr_val),
            .rd_reg(dbg_reg),
            .rd_data(dbg_data[g]),
            .running(thr_running[g]),
            .irq_pend(irq_pend[g])
         );
      end
   endgenerate

   assign dbg_data_t0 = dbg_data[0];
   assign dbg_data_t1 = dbg_data[1];

endmodule

// ==== odrs_defs.vh ====
// shared constants for the dispatch / retirement control block
// assumes inclusion by bare name from every design file of the block
`ifndef ODRS_DEFS_VH
`define ODRS_DEFS_VH

// ==========================================================
// micro-operation classes
`define ODRS_CL_ALU 3'h0
`define ODRS_CL_FP 3'h1
`define ODRS_CL_LD 3'h2
`define ODRS_CL_ST 3'h3
`define ODRS_CL_BR 3'h4

// ==========================================================
// execution pipes
`define ODRS_NPIPE 6
`define ODRS_P_ALU0 3'h0
`define ODRS_P_ALU1 3'h1
`define ODRS_P_FP 3'h2
`define ODRS_P_LD 3'h3
`define ODRS_P_ST 3'h4
`define ODRS_P_BR 3'h5
`define ODRS_LAT_ALU 1
`define ODRS_LAT_FP 4
`define ODRS_LAT_LD 2
`define ODRS_LAT_ST 1
`define ODRS_LAT_BR 1

// ==========================================================
// retirement and thread state
`define ODRS_RET_W 3
`define ODRS_NTHR 2
`define ODRS_ST_HALT 2'h1
`define ODRS_ST_RUN 2'h2

`endif

// ==== odrs_pipe.v ====
// one execution pipe: fixed latency, takes a new entry every cycle
// assumes the caller keeps at most one entry per cycle per pipe
`timescale 1ns/1ns
`include "odrs_defs.vh"

module odrs_pipe #(
   parameter LAT = 1,
   parameter IW = 3
) (
   input wire ref_clk,
   input wire reset_n,
   input wire in_v,
   input wire [IW-1:0] in_idx,
   output wire out_v,
   output wire [IW-1:0] out_idx
);

   reg [LAT-1:0] v_reg;
   reg [IW-1:0] idx_reg [0:LAT-1];
   integer s;
   integer r;

   // ==========================================================
   // stage shift, no stall
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         v_reg <= {LAT{1'b0}};
      end else begin
         v_reg[0] <= in_v;
         for (s = 1; s < LAT; s = s + 1) begin
            v_reg[s] <= v_reg[s-1];
         end
      end
   end

   always @(posedge ref_clk) begin
      idx_reg[0] <= in_idx;
      for (r = 1; r < LAT; r = r + 1) begin
         idx_reg[r] <= idx_reg[r-1];
      end
   end

   assign out_v = v_reg[LAT-1];
   assign out_idx = idx_reg[LAT-1];

endmodule

// ==== odrs_thread_ctx.v ====
// private architectural state of one logical processor
// assumes commit writes arrive oldest slot first within one cycle
`timescale 1ns/1ns
`include "odrs_defs.vh"

module odrs_thread_ctx #(
   parameter RW = 3,
   parameter DW = 16,
   parameter NW = 3
) (
   input wire ref_clk,
   input wire reset_n,
   input wire start,
   input wire halt,
   input wire irq,
   input wire irq_take,
   input wire [NW-1:0] wr_v,
   input wire [NW*RW-1:0] wr_dst,
   input wire [NW*DW-1:0] wr_val,
   input wire [RW-1:0] rd_reg,
   output reg [DW-1:0] rd_data,
   output reg running,
   output reg irq_pend
);

   localparam ST_HALT = `ODRS_ST_HALT;
   localparam ST_RUN = `ODRS_ST_RUN;

   reg [1:0] st_reg;
   reg [1:0] st_next;
   reg [DW-1:0] regs [0:(1<<RW)-1];
   integer i;

   // ==========================================================
   // run state, independent of the other thread
   always @* begin
      case (st_reg)
         ST_HALT: st_next = start ? ST_RUN : ST_HALT;
         ST_RUN: st_next = halt ? ST_HALT : ST_RUN;
         default: st_next = ST_HALT;
      endcase
   end

   // ==========================================================
   // registers and interrupt latch
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         st_reg <= ST_HALT;
         running <= 1'b0;
         irq_pend <= 1'b0;
         rd_data <= {DW{1'b0}};
         for (i = 0; i < (1<<RW); i = i + 1) begin
            regs[i] <= {DW{1'b0}};
         end
      end else begin
         st_reg <= st_next;
         running <= (st_next == ST_RUN);
         // new request wins over the take
         irq_pend <= irq | (irq_pend & ~irq_take);
         // later slot is younger, so it wins a shared target
         for (i = 0; i < NW; i = i + 1) begin
            if (wr_v[i]) begin
               regs[wr_dst[i*RW +: RW]] <= wr_val[i*DW +: DW];
            end
         end
         rd_data <= regs[rd_reg];
      end
   end

endmodule

// ==== odrs_chk_properties.sv ====
// checker for the dispatch / retirement control top module
// assumes single clock ref_clk and synchronous active-low reset_n
`timescale 1ns/1ns
module odrs_chk (
   input wire ref_clk,
   input wire reset_n,
   input wire [1:0] thr_start,
   input wire [1:0] thr_halt,
   input wire [1:0] fe_ready_reg,
   input wire [1:0] thr_running,
   input wire [1:0] irq_ack_reg,
   input wire [1:0] flush_reg,
   input wire [1:0] exc_reg,
   input wire [2:0] issue_cnt_reg,
   input wire bts_v_reg,
   input wire bts_thr_reg,
   input wire bts_mis_reg
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // named steps
   sequence mis0_s;
      bts_v_reg && bts_mis_reg && !bts_thr_reg;
   endsequence
   sequence start0_s;
      thr_start[0] && !thr_halt[0];
   endsequence
   sequence halt1_s;
      thr_halt[1] && !thr_start[1];
   endsequence
   // ==========================================================
   // properties
   issue_max_a: assert property (issue_cnt_reg <= 3'h6)
      else $error("more than six issued in one cycle");
   exc_flush_a: assert property ((exc_reg & ~flush_reg) == 2'h0)
      else $error("exception without flush of its thread");
   exc_pulse_a: assert property (exc_reg[0] |=> !exc_reg[0])
      else $error("exception pulse longer than one cycle");
   irq_flush_a: assert property ((irq_ack_reg & ~flush_reg) == 2'h0)
      else $error("interrupt taken without flush");
   irq_run_a: assert property (irq_ack_reg[1] |-> $past(thr_running[1]))
      else $error("interrupt taken on halted thread");
   ready_run_a: assert property ((fe_ready_reg & ~thr_running) == 2'h0)
      else $error("ready for a thread that is not running");
   start_run_a: assert property (start0_s |=> thr_running[0])
      else $error("thread did not start");
   halt_stop_a: assert property (halt1_s |=> !thr_running[1])
      else $error("thread did not halt");
   mis_flush_a: assert property (mis0_s |-> ##[0:3] flush_reg[0])
      else $error("no flush after mispredicted branch");
endmodule

bind odrs_core odrs_chk odrs_chk_inst (.ref_clk(ref_clk),
   .reset_n(reset_n), .thr_start(thr_start), .thr_halt(thr_halt),
   .fe_ready_reg(fe_ready_reg), .thr_running(thr_running),
   .irq_ack_reg(irq_ack_reg), .flush_reg(flush_reg), .exc_reg(exc_reg),
   .issue_cnt_reg(issue_cnt_reg), .bts_v_reg(bts_v_reg),
   .bts_thr_reg(bts_thr_reg), .bts_mis_reg(bts_mis_reg));

// ==== odrs_fe_model.sv ====
// in-order front end model offering queued micro-operations
// assumes the testbench pushes packed uops by hierarchical call
`timescale 1ns/1ns
module odrs_fe_model (
   input wire ref_clk,
   input wire [1:0] fe_ready_reg,
   input wire [1:0] flush_reg,
   output reg fe_valid,
   output reg [30:0] fe_uop
);
   reg [30:0] q[$];
   reg took;
   task push(input [30:0] u);
      q.push_back(u);
   endtask
   initial begin
      fe_valid = 1'b0;
      fe_uop = 31'h0;
      took = 1'b0;
   end
   // ==========================================================
   // taken when ready for its thread and no flush
   always @(posedge ref_clk) begin
      took <= fe_valid && fe_ready_reg[fe_uop[30]] && !flush_reg[fe_uop[30]];
   end
   // ==========================================================
   // program order, held until taken, idle lines toggle
   always @(negedge ref_clk) begin
      if (took)
         q.delete(0);
      if (q.size() != 0) begin
         fe_valid <= 1'b1;
         fe_uop <= q[0];
      end else begin
         fe_valid <= 1'b0;
         fe_uop <= ~fe_uop;
      end
   end
endmodule

// ==== test_ooo_dispatch_retire_smt.sv ====
// self-checking testbench for the dispatch / retirement control block
// assumes the checker is bound and the front end model drives uops
`timescale 1ns/1ns
`include "odrs_defs.vh"
module test_ooo_dispatch_retire_smt;
   logic ref_clk, reset_n;
   logic [1:0] thr_start, thr_halt, irq_req;
   logic [2:0] dbg_reg;
   wire fe_valid, fe_thread, fe_fault, fe_mispred;
   wire [2:0] fe_class, fe_src1, fe_src2, fe_dst, issue_cnt_reg;
   wire [15:0] fe_val, st_data_reg, bts_target_reg, dbg_data_t0, dbg_data_t1;
   wire [1:0] fe_ready_reg, thr_running, irq_ack_reg, flush_reg, exc_reg;
   wire [1:0] ret_cnt_reg;
   wire st_v_reg, st_thr_reg, bts_v_reg, bts_thr_reg, bts_mis_reg;
   wire [2:0] st_addr_reg;
   int n_errors = 0, checks_done = 0, n_ret = 0, n_bts = 0;
   int n_exc[2] = '{0, 0}, n_ack[2] = '{0, 0};
   logic [31:0] stq[$];
   logic [15:0] bt;
   logic bm;
   always #20 ref_clk = ~ref_clk;
   odrs_core odrs_core_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .fe_valid(fe_valid), .fe_thread(fe_thread), .fe_class(fe_class),
      .fe_src1(fe_src1), .fe_src2(fe_src2), .fe_dst(fe_dst),
      .fe_val(fe_val), .fe_fault(fe_fault), .fe_mispred(fe_mispred),
      .fe_ready_reg(fe_ready_reg), .thr_start(thr_start),
      .thr_halt(thr_halt), .irq_req(irq_req), .thr_running(thr_running),
      .irq_ack_reg(irq_ack_reg), .flush_reg(flush_reg), .exc_reg(exc_reg),
      .issue_cnt_reg(issue_cnt_reg), .ret_cnt_reg(ret_cnt_reg),
      .st_v_reg(st_v_reg), .st_thr_reg(st_thr_reg),
      .st_addr_reg(st_addr_reg), .st_data_reg(st_data_reg),
      .bts_v_reg(bts_v_reg), .bts_thr_reg(bts_thr_reg),
      .bts_target_reg(bts_target_reg), .bts_mis_reg(bts_mis_reg),
      .dbg_reg(dbg_reg), .dbg_data_t0(dbg_data_t0),
      .dbg_data_t1(dbg_data_t1));
   odrs_fe_model odrs_fe_model_inst (.ref_clk(ref_clk),
      .fe_ready_reg(fe_ready_reg), .flush_reg(flush_reg),
      .fe_valid(fe_valid), .fe_uop({fe_thread, fe_class, fe_src1,
      fe_src2, fe_dst, fe_val, fe_fault, fe_mispred}));
   // ==========================================================
   // event monitor
   always @(posedge ref_clk) begin
      if (reset_n === 1'b1) begin
         n_ret += ret_cnt_reg;
         n_exc[0] += exc_reg[0];
         n_exc[1] += exc_reg[1];
         n_ack[0] += irq_ack_reg[0];
         n_ack[1] += irq_ack_reg[1];
         if (st_v_reg === 1'b1)
            stq.push_back({12'h0, st_thr_reg, st_addr_reg, st_data_reg});
         if (bts_v_reg === 1'b1) begin
            n_bts++;
            bt = bts_target_reg;
            bm = bts_mis_reg;
         end
      end
   end
   // ==========================================================
   // shared tasks
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task op(input t, input [2:0] c, input [2:0] s, input [2:0] d,
           input [15:0] v, input f, input m);
      odrs_fe_model_inst.push({t, c, s, 3'h0, d, v, f, m});
   endtask
   task settle;
      int i;
      for (i = 0; i < 200 && odrs_fe_model_inst.q.size() != 0; i++)
         @(negedge ref_clk);
      check(odrs_fe_model_inst.q.size(), 0);
      repeat (12) @(negedge ref_clk);
   endtask
   task rd(input [2:0] r, input [15:0] e0, input [15:0] e1);
      dbg_reg = r;
      repeat (2) @(negedge ref_clk);
      check(dbg_data_t0, e0);
      check(dbg_data_t1, e1);
   endtask
   task pulse(input [1:0] st, input [1:0] hl, input [1:0] iq);
      thr_start = st;
      thr_halt = hl;
      irq_req = iq;
      @(negedge ref_clk);
      thr_start = 2'h0;
      thr_halt = 2'h0;
      irq_req = 2'h0;
      repeat (6) @(negedge ref_clk);
   endtask
   // ==========================================================
   // scenarios
   task test_start;
      pulse(2'h3, 2'h0, 2'h0);
      check(thr_running, 2'h3);
      check(fe_ready_reg, 2'h3);
      $display("test_start done");
   endtask
   task test_order;
      int r0;
      r0 = n_ret;
      op(0, `ODRS_CL_FP, 0, 1, 16'h1111, 0, 0);
      op(0, `ODRS_CL_ALU, 0, 1, 16'h2222, 0, 0);
      op(0, `ODRS_CL_ALU, 0, 2, 16'h3333, 0, 0);
      settle;
      check(n_ret - r0, 3);
      rd(1, 16'h2222, 16'h0);
      rd(2, 16'h3333, 16'h0);
      $display("test_order done");
   endtask
   task test_threads;
      op(1, `ODRS_CL_ALU, 0, 1, 16'h4444, 0, 0);
      op(0, `ODRS_CL_LD, 0, 3, 16'h5555, 0, 0);
      settle;
      rd(1, 16'h2222, 16'h4444);
      rd(3, 16'h5555, 16'h0);
      $display("test_threads done");
   endtask
   task test_store;
      int s;
      s = stq.size();
      op(0, `ODRS_CL_ST, 0, 5, 16'h0a01, 0, 0);
      op(1, `ODRS_CL_ST, 0, 6, 16'h0a02, 0, 0);
      settle;
      check(stq.size() - s, 2);
      check(stq[s], 32'h0005_0a01);
      check(stq[s+1], 32'h000e_0a02);
      $display("test_store done");
   endtask
   task test_fault;
      int e;
      e = n_exc[0];
      op(0, `ODRS_CL_ALU, 0, 4, 16'h0c0c, 0, 0);
      op(0, `ODRS_CL_ALU, 0, 4, 16'h0bad, 1, 0);
      settle;
      check(n_exc[0] - e, 1);
      check(n_exc[1], 0);
      rd(4, 16'h0c0c, 16'h0);
      $display("test_fault done");
   endtask
   task test_mispredict;
      int e, b;
      e = n_exc[0];
      b = n_bts;
      op(0, `ODRS_CL_BR, 0, 0, 16'h0123, 0, 1);
      op(0, `ODRS_CL_ALU, 0, 4, 16'h0dd0, 1, 0);
      settle;
      check(n_exc[0] - e, 0);
      check(n_bts - b, 1);
      check({15'h0, bm, bt}, 32'h0001_0123);
      rd(4, 16'h0c0c, 16'h0);
      $display("test_mispredict done");
   endtask
   task test_irq;
      int a0, a1;
      a0 = n_ack[0];
      a1 = n_ack[1];
      pulse(2'h0, 2'h0, 2'h2);
      check(n_ack[1] - a1, 1);
      check(n_ack[0] - a0, 0);
      check(thr_running, 2'h3);
      $display("test_irq done");
   endtask
   task test_halt;
      int a1;
      pulse(2'h0, 2'h2, 2'h0);
      check(thr_running, 2'h1);
      a1 = n_ack[1];
      pulse(2'h0, 2'h0, 2'h2);
      check(n_ack[1] - a1, 0);
      op(0, `ODRS_CL_ALU, 0, 6, 16'h0e0e, 0, 0);
      op(0, `ODRS_CL_ALU, 6, 7, 16'h0f0f, 0, 0);
      settle;
      rd(7, 16'h0f0f, 16'h0);
      rd(6, 16'h0e0e, 16'h0);
      $display("test_halt done");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      thr_start = 2'h0;
      thr_halt = 2'h0;
      irq_req = 2'h0;
      dbg_reg = 3'h0;
      repeat (16) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      test_start;
      test_order;
      test_threads;
      test_store;
      test_fault;
      test_mispredict;
      test_irq;
      test_halt;
      finish_test;
   end
   initial begin
      #400000;
      n_errors++;
      finish_test;
   end
endmodule
